//--- rtl/monitor_measurement_control_params.svh
`ifndef MONITOR_MEASUREMENT_CONTROL_PARAMS_SVH
`define MONITOR_MEASUREMENT_CONTROL_PARAMS_SVH
// register offsets
`define VOLT_VALUE_BASE_OFS 8'h20
`define REMOTE_ONE_TEMP_OFS 8'h25
`define LOCAL_TEMP_OFS      8'h26
`define REMOTE_TWO_TEMP_OFS 8'h27
`define SECOND_STATUS_OFS   8'h42
`define CODE_OFS            8'h43
`define FAN1_MIN_HIGH_OFS   8'h55
`define SECOND_CONFIG_OFS   8'h73
`define SECOND_MASK_OFS     8'h75
`define FRACTION_OFS        8'h77
// field positions
`define CODE_CHANGE_BIT     0
`define PIN_SELECT_BIT      7
`define SIXTH_CODE_BIT      5
`define AVG_OFF_BIT         4
`define BYPASS_BIT          5
`define SINGLE_BIT          6
`define CHAN_SEL_MSB        7
`define CHAN_SEL_LSB        5
`define REMOTE2_FRAC_LSB    6
`define LOCAL_FRAC_LSB      4
`define REMOTE1_FRAC_LSB    2
// channel codes
`define CH_12V              3'h4
`define FIRST_TEMP_CH       3'h5
// reset values
`define TEMP_RESET          8'h80
`define FRAC_RESET          8'h00
`define CONFIG_RESET        8'h00
`define MASK_RESET          8'h00
`define CODE_RESET          1'h0
`define FAN1_MIN_HIGH_RESET 8'hff
`define VOLT_RESET          8'h00
// timing
`define AVG_COUNT           16
`define CLK_PERIOD_NS       40
`define CODE_SAMPLE_NS      11000
`define VOLT_CONV_NS        711000
`define TEMP_MEAS_NS        25500000
`endif

//--- rtl/monitor_measurement_control_pkg.sv
package monitor_measurement_control_pkg;
    typedef logic [2:0] chan_t;
    typedef enum logic [3:0] {
        SEQ_PACE  = 4'b0001,
        SEQ_START = 4'b0010,
        SEQ_WAIT  = 4'b0100,
        SEQ_STORE = 4'b1000
    } seq_state_e;
    typedef struct packed {
        logic  start;
        chan_t channel;
        logic  bypass;
    } adc_req_s;
    typedef struct packed {
        logic       done;
        logic [9:0] data;
    } adc_rsp_s;
endpackage : monitor_measurement_control_pkg

//--- rtl/monitor_measurement_control.sv
`timescale 1ns/1ps
`include "monitor_measurement_control_params.svh"
// Operation
// - flag when code differs from 11 us earlier
// - detection only in sixth-input mode, status bit0
// - voltages average sixteen conversions by default
// - config bit4 gives single-conversion voltage results
// - config bit5 bypasses all input attenuators
// - config bit6 converts only selected channel
// - fan1 high bits 7:5 select channel
// - local temperature msbs at 26h
// - ten-bit twos complement, quarter degree steps
// - remote temperature averages sixteen cycles
// - fractions of channels in shared register
// - fraction fields at 7:6, 5:4, 3:2
// - two lsbs weigh half and quarter degree
// - code bit7 selects pin function
// - fraction read freezes temperature results until all three msbs read
module monitor_measurement_control
    import monitor_measurement_control_pkg::*;
#(
    parameter int VOLT_CONV_CYCLES = `VOLT_CONV_NS / `CLK_PERIOD_NS,
    parameter int TEMP_CONV_CYCLES = `TEMP_MEAS_NS / (`AVG_COUNT * `CLK_PERIOD_NS)
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // code pins, bit 5 is the shared pin
    input  wire logic [5:0] voltage_identification_code,
    input  wire logic       over_limit_12v,
    // converter front end
    output adc_req_s        adc_req,
    input  wire adc_rsp_s   adc_rsp,
    // alert
    output logic            irq
);
    // longest window rounds down
    localparam int CODE_SAMPLE_CYCLES = `CODE_SAMPLE_NS / `CLK_PERIOD_NS;
    localparam int AVG_SHIFT          = $clog2(`AVG_COUNT);

    logic       [8:0]  code_tick_cnt_r;
    logic              code_tick;
    logic       [7:0]  config_r;
    logic       [7:0]  mask_r;
    logic       [7:0]  fan1_high_r;
    logic              pin_sel_r;
    logic       [5:0]  code_now;
    logic       [5:0]  code_prev_r;
    logic              change_event;
    logic              flag_event;
    logic              flag_r;
    logic              status_clr;
    seq_state_e        state_r;
    chan_t             chan_r;
    chan_t             chan_nxt;
    logic       [19:0] pace_r;
    logic              pace_done;
    logic       [13:0] sum_r;
    logic       [13:0] sample_ext;
    logic       [4:0]  count_r;
    logic       [4:0]  needed;
    logic              is_temp;
    logic       [9:0]  result;
    logic              store;
    logic       [7:0]  volt_r [0:4];
    logic       [9:0]  temp_work_r [0:2];
    logic       [9:0]  temp_vis_r [0:2];
    logic       [2:0]  pend_r;
    logic              freeze_r;
    logic              frac_read;
    logic       [7:0]  rd_val;

    // code sampling tick
    assign code_tick = (code_tick_cnt_r == 9'(CODE_SAMPLE_CYCLES - 1));

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            code_tick_cnt_r <= 9'h000;
        end else if (code_tick) begin
            code_tick_cnt_r <= 9'h000;
        end else begin
            code_tick_cnt_r <= code_tick_cnt_r + 9'h001;
        end
    end

    // software registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            config_r    <= `CONFIG_RESET;
            mask_r      <= `MASK_RESET;
            fan1_high_r <= `FAN1_MIN_HIGH_RESET;
            pin_sel_r   <= `CODE_RESET;
        end else if (reg_write) begin
            if (reg_addr == `SECOND_CONFIG_OFS) begin
                config_r <= reg_wdata;
            end else if (reg_addr == `SECOND_MASK_OFS) begin
                mask_r <= reg_wdata;
            end else if (reg_addr == `FAN1_MIN_HIGH_OFS) begin
                fan1_high_r <= reg_wdata;
            end else if (reg_addr == `CODE_OFS) begin
                pin_sel_r <= reg_wdata[`PIN_SELECT_BIT];
            end
        end
    end

    // shared pin reads as zero while it measures 12 V
    assign code_now = pin_sel_r ? voltage_identification_code
                                : {1'b0, voltage_identification_code[4:0]};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            code_prev_r <= 6'h00;
        end else if (code_tick) begin
            code_prev_r <= code_now;
        end
    end

    // compares against the sample one tick back, so a glitch between ticks is missed
    assign change_event = code_tick && pin_sel_r && (code_now != code_prev_r);
    assign flag_event   = pin_sel_r ? change_event : over_limit_12v;
    assign status_clr   = reg_read && (reg_addr == `SECOND_STATUS_OFS);

    // an event in the clearing cycle wins over the read
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else if (flag_event) begin
            flag_r <= 1'b1;
        end else if (status_clr) begin
            flag_r <= 1'b0;
        end
    end

    assign irq = flag_r && !mask_r[`CODE_CHANGE_BIT];

    // conversion sequencer
    assign is_temp   = (chan_r >= `FIRST_TEMP_CH);
    assign needed    = (!is_temp && config_r[`AVG_OFF_BIT]) ? 5'h01 : 5'(`AVG_COUNT);
    assign pace_done = is_temp ? (pace_r == 20'(TEMP_CONV_CYCLES - 1))
                               : (pace_r == 20'(VOLT_CONV_CYCLES - 1));
    assign sample_ext = is_temp ? {{4{adc_rsp.data[9]}}, adc_rsp.data}
                                : {4'h0, adc_rsp.data};
    // arithmetic shift keeps the sign of temperature averages
    assign result = (needed == 5'h01) ? sum_r[9:0]
                                      : 10'($signed(sum_r) >>> AVG_SHIFT);
    assign store  = (state_r == SEQ_STORE);

    always_comb begin
        chan_nxt = chan_r + 3'h1;
        if (config_r[`SINGLE_BIT]) begin
            chan_nxt = fan1_high_r[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
        end else if (pin_sel_r && (chan_nxt == `CH_12V)) begin
            chan_nxt = `FIRST_TEMP_CH;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= SEQ_PACE;
            pace_r  <= 20'h00000;
        end else begin
            case (state_r)
                SEQ_PACE: begin
                    if (pace_done) begin
                        pace_r  <= 20'h00000;
                        state_r <= SEQ_START;
                    end else begin
                        pace_r <= pace_r + 20'h00001;
                    end
                end
                SEQ_START: begin
                    state_r <= SEQ_WAIT;
                end
                SEQ_WAIT: begin
                    if (adc_rsp.done) begin
                        state_r <= ((count_r + 5'h01) >= needed) ? SEQ_STORE : SEQ_PACE;
                    end
                end
                SEQ_STORE: begin
                    state_r <= SEQ_PACE;
                end
                default: begin
                    state_r <= SEQ_PACE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sum_r   <= 14'h0000;
            count_r <= 5'h00;
        end else if (store) begin
            sum_r   <= 14'h0000;
            count_r <= 5'h00;
        end else if ((state_r == SEQ_WAIT) && adc_rsp.done) begin
            sum_r   <= sum_r + sample_ext;
            count_r <= count_r + 5'h01;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chan_r <= 3'h0;
        end else if (store) begin
            chan_r <= chan_nxt;
        end
    end

    assign adc_req.start   = (state_r == SEQ_START);
    assign adc_req.channel = chan_r;
    assign adc_req.bypass  = config_r[`BYPASS_BIT];

    // result storage
    generate
        for (genvar i = 0; i < 5; i++) begin : g_volt
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    volt_r[i] <= `VOLT_RESET;
                end else if (store && (chan_r == 3'(i))) begin
                    volt_r[i] <= result[9:2];
                end
            end
        end
        for (genvar t = 0; t < 3; t++) begin : g_temp
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    temp_work_r[t] <= {`TEMP_RESET, 2'h0};
                end else if (store && (chan_r == 3'(t + 5))) begin
                    temp_work_r[t] <= result;
                end
            end
            // visible copy trails the working value while not frozen
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    temp_vis_r[t] <= {`TEMP_RESET, 2'h0};
                end else if (!freeze_r) begin
                    temp_vis_r[t] <= temp_work_r[t];
                end
            end
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    pend_r[t] <= 1'b0;
                end else if (frac_read) begin
                    pend_r[t] <= 1'b1;
                end else if (reg_read && (reg_addr == (`REMOTE_ONE_TEMP_OFS + 8'(t)))) begin
                    pend_r[t] <= 1'b0;
                end
            end
        end
    endgenerate

    assign frac_read = reg_read && (reg_addr == `FRACTION_OFS);

    // freeze ends once every temperature msb register has been read
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            freeze_r <= 1'b0;
        end else if (frac_read) begin
            freeze_r <= 1'b1;
        end else if (freeze_r && (pend_r == 3'h0)) begin
            freeze_r <= 1'b0;
        end
    end

    // read decode
    always_comb begin
        rd_val = 8'h00;
        if (reg_addr == `REMOTE_ONE_TEMP_OFS) begin
            rd_val = temp_vis_r[0][9:2];
        end else if (reg_addr == `LOCAL_TEMP_OFS) begin
            rd_val = temp_vis_r[1][9:2];
        end else if (reg_addr == `REMOTE_TWO_TEMP_OFS) begin
            rd_val = temp_vis_r[2][9:2];
        end else if (reg_addr == `FRACTION_OFS) begin
            rd_val = `FRAC_RESET;
            rd_val[`REMOTE2_FRAC_LSB +: 2] = temp_vis_r[2][1:0];
            rd_val[`LOCAL_FRAC_LSB +: 2]   = temp_vis_r[1][1:0];
            rd_val[`REMOTE1_FRAC_LSB +: 2] = temp_vis_r[0][1:0];
        end else if (reg_addr == `SECOND_STATUS_OFS) begin
            rd_val[`CODE_CHANGE_BIT] = flag_r;
        end else if (reg_addr == `CODE_OFS) begin
            rd_val = {pin_sel_r, 1'b0, code_now};
        end else if (reg_addr == `FAN1_MIN_HIGH_OFS) begin
            rd_val = fan1_high_r;
        end else if (reg_addr == `SECOND_CONFIG_OFS) begin
            rd_val = config_r;
        end else if (reg_addr == `SECOND_MASK_OFS) begin
            rd_val = mask_r;
        end else if ((reg_addr >= `VOLT_VALUE_BASE_OFS) && (reg_addr < `REMOTE_ONE_TEMP_OFS)) begin
            rd_val = volt_r[3'(reg_addr - `VOLT_VALUE_BASE_OFS)];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rd_val;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : monitor_measurement_control

//--- sim/monitor_measurement_control_asserts.sv
`timescale 1ns/1ps
module monitor_measurement_control_asserts
    import monitor_measurement_control_pkg::*;
#(
    parameter int VOLT_CONV_CYCLES = 8,
    parameter int TEMP_CONV_CYCLES = 12
) (
    // clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // pins, converter, alert
    input wire logic [5:0] voltage_identification_code,
    input wire logic       over_limit_12v,
    input wire adc_req_s   adc_req,
    input wire adc_rsp_s   adc_rsp,
    input wire logic       irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // the bench runs the voltage pacing wait at eight cycles, temperature at twelve
    start_pacing_a: assert property (adc_req.start |=> !adc_req.start [*8])
        else $error("conversion requests too close");
    mask_blocks_a: assert property (reg_write && reg_addr == 8'h75 && reg_wdata[0] |=> !irq)
        else $error("alert despite mask");
    status_read_a: assert property (irq && reg_read && reg_addr == 8'h42 |=> reg_rdata[0])
        else $error("flag lost before status read");
    irq_fall_a: assert property ($fell(irq) |->
        $past(reg_read) && $past(reg_addr) == 8'h42 || $past(reg_write) && $past(reg_addr) == 8'h75)
        else $error("alert dropped without cause");
    code_bits_a: assert property (reg_read && reg_addr == 8'h43 |=>
        reg_rdata[4:0] == $past(voltage_identification_code[4:0]))
        else $error("code bits wrong");
    pin5_masked_a: assert property (reg_read && reg_addr == 8'h43 |=> reg_rdata[7] || !reg_rdata[5])
        else $error("shared pin visible in supply mode");
    frac_zero_a: assert property (reg_read && reg_addr == 8'h77 |=> reg_rdata[1:0] == 2'b00)
        else $error("unused fraction bits set");
    bypass_follow_a: assert property (reg_write && reg_addr == 8'h73 |->
        ##2 adc_req.bypass == $past(reg_wdata[5], 2))
        else $error("bypass does not follow config");
endmodule : monitor_measurement_control_asserts

//--- sim/adc_front_end_model.sv
`timescale 1ns/1ps
module adc_front_end_model
    import monitor_measurement_control_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // converter side
    input  wire adc_req_s   adc_req,
    output adc_rsp_s        adc_rsp,
    // offset on every temperature sample
    input  wire logic [9:0] temp_add
);
    logic [2:0] left_r;
    logic       odd_r;
    chan_t      chan_r;
    logic [9:0] base;

    // samples alternate base and base+8, so a true average lands on base+4
    always_comb begin
        case (chan_r)
            3'h5: base = 10'h062 + temp_add;
            3'h6: base = 10'h025 + temp_add;
            3'h7: base = 10'h0c7 + temp_add;
            default: base = {chan_r, 7'h40};
        endcase
    end

    // prompt and slow answers alternate; data is garbage outside done
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            left_r <= 3'h0;
            odd_r <= 1'b0;
            chan_r <= 3'h0;
            adc_rsp <= '0;
        end else begin
            adc_rsp.done <= 1'b0;
            adc_rsp.data <= ~adc_rsp.data;
            if (adc_req.start) begin
                chan_r <= adc_req.channel;
                left_r <= odd_r ? 3'h6 : 3'h1;
                odd_r <= ~odd_r;
            end else if (left_r != 3'h0) begin
                left_r <= left_r - 3'h1;
                if (left_r == 3'h1) begin
                    adc_rsp.done <= 1'b1;
                    adc_rsp.data <= base + (odd_r ? 10'h000 : 10'h008);
                end
            end
        end
    end
endmodule : adc_front_end_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import monitor_measurement_control_pkg::*;
;
    typedef struct packed {
        logic [3:0] dly;
        logic       wr;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_s;
    logic       clock, reset_n, reg_write, reg_read, over_limit_12v, irq, seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [5:0] voltage_identification_code;
    logic [9:0] temp_add;
    adc_req_s   adc_req;
    adc_rsp_s   adc_rsp;
    int         num_errors, checked, cycles;
    // dly counts 256-cycle steps before the row
    row_s       rows [0:20] = '{
        '{4'h0, 1'b0, 8'h77, 8'h00, 8'h00}, '{4'h0, 1'b0, 8'h25, 8'h00, 8'h80},
        '{4'h0, 1'b0, 8'h26, 8'h00, 8'h80}, '{4'h0, 1'b0, 8'h27, 8'h00, 8'h80},
        '{4'h0, 1'b0, 8'h73, 8'h00, 8'h00}, '{4'h0, 1'b0, 8'h75, 8'h00, 8'h00},
        '{4'h0, 1'b0, 8'h55, 8'h00, 8'hff}, '{4'h0, 1'b0, 8'h42, 8'h00, 8'h00},
        '{4'h0, 1'b0, 8'h43, 8'h00, 8'h00}, '{4'h0, 1'b0, 8'h00, 8'h00, 8'h00},
        '{4'h0, 1'b1, 8'h26, 8'h55, 8'h80}, '{4'h0, 1'b1, 8'h55, 8'ha5, 8'ha5},
        '{4'h0, 1'b1, 8'h75, 8'h01, 8'h01}, '{4'h0, 1'b1, 8'h73, 8'h20, 8'h20},
        '{4'h0, 1'b1, 8'h75, 8'h00, 8'h00}, '{4'hc, 1'b0, 8'h77, 8'h00, 8'hd8},
        '{4'h0, 1'b0, 8'h25, 8'h00, 8'h19}, '{4'h0, 1'b0, 8'h26, 8'h00, 8'h0a},
        '{4'h0, 1'b0, 8'h27, 8'h00, 8'h32}, '{4'h0, 1'b0, 8'h20, 8'h00, 8'h11},
        '{4'h0, 1'b0, 8'h24, 8'h00, 8'h91}};

    monitor_measurement_control #(.VOLT_CONV_CYCLES(8), .TEMP_CONV_CYCLES(12)) dut (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .voltage_identification_code(voltage_identification_code),
        .over_limit_12v(over_limit_12v), .adc_req(adc_req), .adc_rsp(adc_rsp), .irq(irq));
    adc_front_end_model model (.clock(clock), .reset_n(reset_n), .adc_req(adc_req),
        .adc_rsp(adc_rsp), .temp_add(temp_add));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic report_and_stop;
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            $display("ERROR %0t: timeout", $time);
            report_and_stop();
        end
    end

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    // strobes drop one cycle after they rise, so no task raises what another just lowered
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        // read data stand only in this cycle, so take them mid-cycle where they are settled
        @(negedge clock);
        v = reg_rdata;
        @(posedge clock);
    endtask : rd

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        cmp(v, e);
    endtask : chk

    initial begin
        reset_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        over_limit_12v = 1'b0;
        voltage_identification_code = 6'h00;
        temp_add = 10'h000;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        foreach (rows[i]) begin
            repeat (rows[i].dly * 256) @(posedge clock);
            if (rows[i].wr) wr(rows[i].a, rows[i].d);
            chk(rows[i].a, rows[i].e);
        end
        temp_add <= 10'h004;
        chk(8'h77, 8'hd8);
        repeat (3000) @(posedge clock);
        chk(8'h25, 8'h19);
        chk(8'h26, 8'h0a);
        chk(8'h27, 8'h32);
        repeat (3000) @(posedge clock);
        chk(8'h25, 8'h1a);
        // remote 1 samples straddle zero, so a lost sign extension reads as -128
        temp_add <= 10'h39a;
        repeat (3000) @(posedge clock);
        chk(8'h77, 8'h70);
        chk(8'h25, 8'h00);
        chk(8'h26, 8'hf0);
        chk(8'h27, 8'h19);
        wr(8'h43, 8'h80);
        repeat (700) @(posedge clock);
        rd(8'h42);
        voltage_identification_code <= 6'h21;
        for (int i = 0; i < 280 && irq !== 1'b1; i++) @(posedge clock);
        cmp({7'h00, irq}, 8'h01);
        chk(8'h43, 8'ha1);
        repeat (300) @(posedge clock);
        cmp({7'h00, irq}, 8'h01);
        chk(8'h42, 8'h01);
        chk(8'h42, 8'h00);
        cmp({7'h00, irq}, 8'h00);
        wr(8'h75, 8'h01);
        voltage_identification_code <= 6'h03;
        seen = 1'b0;
        repeat (600) begin
            @(posedge clock);
            if (irq !== 1'b0) seen = 1'b1;
        end
        cmp({7'h00, seen}, 8'h00);
        chk(8'h42, 8'h01);
        wr(8'h75, 8'h00);
        wr(8'h43, 8'h00);
        voltage_identification_code <= 6'h3c;
        repeat (600) @(posedge clock);
        chk(8'h42, 8'h00);
        chk(8'h43, 8'h1c);
        over_limit_12v <= 1'b1;
        @(posedge clock);
        chk(8'h42, 8'h01);
        over_limit_12v <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            wr(8'h55, {c[2:0], 5'h00});
            wr(8'h73, 8'h70);
            repeat (600) @(posedge clock);
            for (int i = 0; i < 40 && adc_req.start !== 1'b1; i++) @(posedge clock);
            cmp({4'h0, adc_req.channel, adc_req.bypass}, {4'h0, c[2:0], 1'b1});
            rd(8'h20 + 8'(c));
            cmp(v & 8'hfd, {c[2:0], 5'h10});
        end
        reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        cmp({7'h00, irq}, 8'h00);
        chk(8'h73, 8'h00);
        chk(8'h25, 8'h80);
        report_and_stop();
    end
endmodule : tb_top

bind monitor_measurement_control monitor_measurement_control_asserts #(
    .VOLT_CONV_CYCLES(VOLT_CONV_CYCLES), .TEMP_CONV_CYCLES(TEMP_CONV_CYCLES)) checker_i (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .voltage_identification_code(voltage_identification_code),
    .over_limit_12v(over_limit_12v), .adc_req(adc_req), .adc_rsp(adc_rsp), .irq(irq));
